//--- logic/fbbse_pkg.sv
// Package for the flag, branch, bit and shift execution block.
// Assumes a 16-bit instruction word and a 12-bit APB byte address.
package fbbse_pkg;

    // Widths
    localparam int unsigned PC_W = 16;
    localparam int unsigned ADDR_W = 12;

    // APB byte addresses and register pages
    localparam logic [11:0] ADDR_INSTR = 12'h000;
    localparam logic [11:0] ADDR_PC = 12'h004;
    localparam logic [11:0] ADDR_STATUS_FLAGS_REGISTER = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    localparam logic [3:0] PAGE_GPR = 4'h1;
    localparam logic [3:0] PAGE_IO = 4'h2;

    // Instruction word fields
    localparam int unsigned OP_MSB = 15;
    localparam int unsigned OP_LSB = 11;
    localparam int unsigned IDX_MSB = 10;
    localparam int unsigned IDX_LSB = 8;

    // Operation codes
    localparam logic [4:0] OP_BR_HC_LOW = 5'h00;
    localparam logic [4:0] OP_BR_T_HIGH = 5'h01;
    localparam logic [4:0] OP_BR_T_LOW = 5'h02;
    localparam logic [4:0] OP_BR_V_HIGH = 5'h03;
    localparam logic [4:0] OP_BR_V_LOW = 5'h04;
    localparam logic [4:0] OP_BR_IRQ_ON = 5'h05;
    localparam logic [4:0] OP_BR_IRQ_OFF = 5'h06;
    localparam logic [4:0] OP_IO_SET = 5'h08;
    localparam logic [4:0] OP_IO_CLR = 5'h09;
    localparam logic [4:0] OP_SHL = 5'h0a;
    localparam logic [4:0] OP_SHR = 5'h0b;
    localparam logic [4:0] OP_ROL = 5'h0c;
    localparam logic [4:0] OP_ROR = 5'h0d;
    localparam logic [4:0] OP_SWAP = 5'h0e;
    localparam logic [4:0] OP_BIT_TO_T = 5'h10;
    localparam logic [4:0] OP_T_TO_BIT = 5'h11;
    localparam logic [4:0] OP_FLAG_ONE = 5'h12;
    localparam logic [4:0] OP_FLAG_ZERO = 5'h13;

    // Status flag positions
    localparam int unsigned FL_C = 0;
    localparam int unsigned FL_Z = 1;
    localparam int unsigned FL_N = 2;
    localparam int unsigned FL_V = 3;
    localparam int unsigned FL_S = 4;
    localparam int unsigned FL_H = 5;
    localparam int unsigned FL_T = 6;
    localparam int unsigned FL_I = 7;

    // Status register bits and reset values
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_BAD = 1;
    localparam int unsigned ST_CYC_LSB = 2;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] STATUS_FLAGS_REGISTER_RST = 8'h00;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;

    // Execution states
    typedef enum logic [1:0] {FB_IDLE, FB_BRANCH, FB_IO_WRITE} fbbse_state_t;

endpackage : fbbse_pkg

//--- logic/fbbse_shift.sv
// Shift, rotate and nibble swap unit with its flag results.
// Purely combinational; the caller chooses when results are stored.
`timescale 1ns/1ps
module fbbse_shift
    import fbbse_pkg::*;
(
    // Operation and operand
    input wire logic [4:0] op,
    input wire logic [7:0] val,
    input wire logic c_in,
    // Result and flags
    output logic [7:0] res,
    output logic c_out,
    output logic z_out,
    output logic n_out,
    output logic v_out
);

    // Result and carry per operation
    always_comb begin
        res = val;
        c_out = c_in;
        case (op)
            OP_SHL: begin
                res = {val[6:0], 1'b0}; // RL10
                c_out = val[7];
            end
            OP_SHR: begin
                res = {1'b0, val[7:1]}; // RL11
                c_out = val[0];
            end
            OP_ROL: begin
                res = {val[6:0], c_in}; // RL12
                c_out = val[7];
            end
            OP_ROR: begin
                res = {c_in, val[7:1]}; // RL13
                c_out = val[0];
            end
            OP_SWAP: res = {val[3:0], val[7:4]}; // RL18
            default: res = val;
        endcase
    end

    // Flags derived from the result
    assign z_out = (res == 8'h00);
    assign n_out = res[7];
    assign v_out = res[7] ^ c_out;

endmodule : fbbse_shift

//--- logic/fbbse_branch.sv
// Condition test and relative target for the flag branches.
// Purely combinational; offset is a signed 8-bit word count.
`timescale 1ns/1ps
module fbbse_branch
    import fbbse_pkg::*;
(
    // Operation and state
    input wire logic [4:0] op,
    input wire logic [7:0] status_flags_register,
    input wire logic [15:0] pc,
    input wire logic [7:0] offset,
    // Decision
    output logic is_branch,
    output logic taken,
    output logic [15:0] target
);

    // Condition per branch kind
    always_comb begin
        is_branch = 1'b1;
        taken = 1'b0;
        case (op)
            OP_BR_HC_LOW: taken = ~status_flags_register[FL_H]; // RL1
            OP_BR_T_HIGH: taken = status_flags_register[FL_T]; // RL2
            OP_BR_T_LOW: taken = ~status_flags_register[FL_T]; // RL3
            OP_BR_V_HIGH: taken = status_flags_register[FL_V]; // RL4
            OP_BR_V_LOW: taken = ~status_flags_register[FL_V]; // RL5
            OP_BR_IRQ_ON: taken = status_flags_register[FL_I]; // RL6
            OP_BR_IRQ_OFF: taken = ~status_flags_register[FL_I]; // RL7
            default: is_branch = 1'b0;
        endcase
    end

    // Signed offset plus one
    assign target = pc + {{8{offset[7]}}, offset} + 16'h0001; // RL20

endmodule : fbbse_branch

//--- logic/fbbse_core.sv
// Execution block for flag branches, I/O bit set/clear, shifts and flag ops.
// Assumes an APB master issues instructions and reaches all state; one clock.
// Operation
// (RL1) Branch when half-carry clear, one/two cycles
// (RL2) Branch when transfer flag set
// (RL3) Branch when transfer flag clear
// (RL4) Branch when overflow set
// (RL5) Branch when overflow clear
// (RL6) Branch when interrupts enabled
// (RL7) Branch when interrupts disabled
// (RL8) Set I/O bit in two cycles
// (RL9) Clear I/O bit in two cycles
// (RL10) Shift left, zero in, flags update
// (RL11) Shift right, zero in, flags update
// (RL12) Rotate left through carry
// (RL13) Rotate right through carry
// (RL14) Copy register bit into transfer flag
// (RL15) Copy transfer flag into register bit
// (RL16) Set/clear each status flag alone
// (RL17) Set/clear half-carry flag alone
// (RL18) Swap register nibbles, flags untouched
// (RL19) Indexed flag set or clear
// (RL20) Branch: one cycle untaken, two taken
`timescale 1ns/1ps
module fbbse_core
    import fbbse_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core state view
    output logic [15:0] pc_out,
    output logic [7:0] status_flags_register_out,
    output logic busy
);

    // State
    fbbse_state_t state_q, state_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0] status_flags_register_q, status_flags_register_d;
    logic [15:0] instr_q;
    logic [15:0] target_q;
    logic [5:0] io_addr_q;
    logic [2:0] io_bit_q;
    logic io_val_q;
    logic bad_q;
    logic [1:0] cyc_q;
    logic [7:0] gpr_q [32];
    logic [7:0] io_q [64];

    // APB decode
    wire access = psel & penable & pready;
    wire wr = access & pwrite;
    wire hit_instr = (paddr == ADDR_INSTR);
    wire hit_pc = (paddr == ADDR_PC);
    wire hit_status_flags_register = (paddr == ADDR_STATUS_FLAGS_REGISTER);
    wire hit_status = (paddr == ADDR_STATUS);
    wire hit_gpr = (paddr[11:8] == PAGE_GPR) & ~paddr[7];
    wire hit_io = (paddr[11:8] == PAGE_IO);
    wire mapped = hit_instr | hit_pc | hit_status_flags_register | hit_status | hit_gpr | hit_io;
    wire [4:0] gpr_idx = paddr[6:2];
    wire [5:0] io_idx = paddr[7:2];

    // Stall every access while an instruction is in its second cycle
    assign pready = ce & (state_q == FB_IDLE);
    assign pslverr = access & ~mapped;
    assign busy = (state_q != FB_IDLE);
    assign pc_out = pc_q;
    assign status_flags_register_out = status_flags_register_q;

    // Instruction fields, taken on an accepted instruction write
    wire exec = wr & hit_instr;
    wire [4:0] op = pwdata[OP_MSB:OP_LSB];
    wire [2:0] idx = pwdata[IDX_MSB:IDX_LSB];
    wire [7:0] opnd = pwdata[7:0];
    wire [4:0] rd = opnd[4:0];
    wire [5:0] io_a = opnd[5:0];
    wire [7:0] rd_val = gpr_q[rd];
    wire bit_sel = rd_val[idx];

    // Operation classes
    wire is_shift = (op == OP_SHL) | (op == OP_SHR) | (op == OP_ROL) | (op == OP_ROR);
    wire is_swap = (op == OP_SWAP);
    wire is_io = (op == OP_IO_SET) | (op == OP_IO_CLR);
    wire is_to_t = (op == OP_BIT_TO_T);
    wire is_from_t = (op == OP_T_TO_BIT);
    wire is_fl_one = (op == OP_FLAG_ONE);
    wire is_fl_zero = (op == OP_FLAG_ZERO);
    wire br_is;
    wire br_taken;
    wire [15:0] br_target;
    wire known = br_is | is_shift | is_swap | is_io | is_to_t | is_from_t
        | is_fl_one | is_fl_zero;

    // Shift unit results
    wire [7:0] sh_res;
    wire sh_c;
    wire sh_z;
    wire sh_n;
    wire sh_v;

    fbbse_shift u_shift (
        .op(op),
        .val(rd_val),
        .c_in(status_flags_register_q[FL_C]),
        .res(sh_res),
        .c_out(sh_c),
        .z_out(sh_z),
        .n_out(sh_n),
        .v_out(sh_v)
    );

    fbbse_branch u_branch (
        .op(op),
        .status_flags_register(status_flags_register_q),
        .pc(pc_q),
        .offset(opnd),
        .is_branch(br_is),
        .taken(br_taken),
        .target(br_target)
    );

    // Register written back by a bit load
    wire [7:0] bld_val = (rd_val & ~(8'h01 << idx)) | ({7'h00, status_flags_register_q[FL_T]} << idx);

    // I/O bit read-modify-write value for the second cycle
    wire [7:0] io_mod = (io_q[io_addr_q] & ~(8'h01 << io_bit_q))
        | ({7'h00, io_val_q} << io_bit_q);

    // Next state and program counter
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        unique case (state_q)
            FB_IDLE: begin
                if (exec && br_is && br_taken) begin
                    state_d = FB_BRANCH; // RL20
                end else if (exec && is_io) begin
                    state_d = FB_IO_WRITE; // RL8
                end else if (exec) begin
                    pc_d = pc_q + 16'h0001; // RL20
                end else if (wr && hit_pc) begin
                    pc_d = pwdata[15:0];
                end
            end
            FB_BRANCH: begin
                state_d = FB_IDLE;
                pc_d = target_q; // RL1
            end
            FB_IO_WRITE: begin
                state_d = FB_IDLE;
                pc_d = pc_q + 16'h0001;
            end
        endcase
    end

    // Status flag updates
    always_comb begin
        status_flags_register_d = status_flags_register_q;
        if (wr && hit_status_flags_register) begin
            status_flags_register_d = pwdata[7:0];
        end else if (exec && is_shift) begin
            status_flags_register_d[FL_C] = sh_c; // RL10
            status_flags_register_d[FL_Z] = sh_z;
            status_flags_register_d[FL_N] = sh_n;
            status_flags_register_d[FL_V] = sh_v;
        end else if (exec && is_to_t) begin
            status_flags_register_d[FL_T] = bit_sel; // RL14
        end else if (exec && is_fl_one) begin
            status_flags_register_d[idx] = 1'b1; // RL16 RL17 RL19
        end else if (exec && is_fl_zero) begin
            status_flags_register_d[idx] = 1'b0; // RL16 RL17 RL19
        end
    end

    // Control registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= FB_IDLE;
            pc_q <= PC_RST;
            status_flags_register_q <= STATUS_FLAGS_REGISTER_RST;
        end else if (ce) begin
            state_q <= state_d;
            pc_q <= pc_d;
            status_flags_register_q <= status_flags_register_d;
        end
    end

    // Instruction latch and second-cycle operands
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            instr_q <= 16'h0000;
            target_q <= PC_RST;
            io_addr_q <= 6'h00;
            io_bit_q <= 3'h0;
            io_val_q <= 1'b0;
            cyc_q <= CYC_ONE;
        end else if (ce && exec) begin
            instr_q <= pwdata[15:0];
            target_q <= br_target;
            io_addr_q <= io_a;
            io_bit_q <= idx;
            io_val_q <= (op == OP_IO_SET); // RL8 RL9
            cyc_q <= ((br_is && br_taken) || is_io) ? CYC_TWO : CYC_ONE;
        end
    end

    // Unknown-op sticky flag, cleared by writing one; a new event wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bad_q <= 1'b0;
        end else if (ce) begin
            if (exec && !known) begin
                bad_q <= 1'b1;
            end else if (wr && hit_status && pwdata[ST_BAD]) begin
                bad_q <= 1'b0;
            end
        end
    end

    // General registers
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (wr && hit_gpr) begin
                gpr_q[gpr_idx] <= pwdata[7:0];
            end else if (exec && (is_shift || is_swap)) begin
                gpr_q[rd] <= sh_res; // RL11 RL12 RL13 RL18
            end else if (exec && is_from_t) begin
                gpr_q[rd] <= bld_val; // RL15
            end
        end
    end

    // I/O space, bit write lands in the second cycle
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (state_q == FB_IO_WRITE) begin
                io_q[io_addr_q] <= io_mod; // RL8 RL9
            end else if (wr && hit_io) begin
                io_q[io_idx] <= pwdata[7:0];
            end
        end
    end

    // Read data
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_instr) begin
            prdata = {16'h0000, instr_q};
        end else if (hit_pc) begin
            prdata = {16'h0000, pc_q};
        end else if (hit_status_flags_register) begin
            prdata = {24'h00_0000, status_flags_register_q};
        end else if (hit_status) begin
            prdata = {28'h000_0000, cyc_q, bad_q, busy};
        end else if (hit_gpr) begin
            prdata = {24'h00_0000, gpr_q[gpr_idx]};
        end else if (hit_io) begin
            prdata = {24'h00_0000, io_q[io_idx]};
        end
    end

    // Checks
    property p_br_taken;
        @(posedge clk_sys) disable iff (rst || !ce)
        (exec && br_is && br_taken) |=> busy ##1 (!busy && pc_q == $past(target_q));
    endproperty
    a_br_taken: assert property (p_br_taken) else $error("taken branch pc wrong"); // RL20

    property p_br_not;
        @(posedge clk_sys) disable iff (rst || !ce)
        (exec && br_is && !br_taken) |=> (!busy && pc_q == $past(pc_q) + 16'h0001);
    endproperty
    a_br_not: assert property (p_br_not) else $error("untaken branch wrong"); // RL20

    property p_hc_low;
        @(posedge clk_sys) disable iff (rst)
        (exec && op == OP_BR_HC_LOW) |=> (busy == !$past(status_flags_register_q[FL_H]));
    endproperty
    a_hc_low: assert property (p_hc_low) else $error("half-carry branch test"); // RL1

    property p_t_high;
        @(posedge clk_sys) disable iff (rst)
        (exec && op == OP_BR_T_HIGH) |=> (busy == $past(status_flags_register_q[FL_T]));
    endproperty
    a_t_high: assert property (p_t_high) else $error("transfer branch test"); // RL2

    property p_br_flags;
        @(posedge clk_sys) disable iff (rst || !ce)
        (exec && br_is) |=> (status_flags_register_q == $past(status_flags_register_q));
    endproperty
    a_br_flags: assert property (p_br_flags) else $error("branch altered flags"); // RL4

    property p_io_set;
        @(posedge clk_sys) disable iff (rst || !ce)
        (exec && op == OP_IO_SET) |=> busy ##1 (!busy && io_q[io_addr_q][io_bit_q]);
    endproperty
    a_io_set: assert property (p_io_set) else $error("io bit not set"); // RL8

    property p_io_clr;
        @(posedge clk_sys) disable iff (rst || !ce)
        (exec && op == OP_IO_CLR) |=> busy ##1 (!busy && !io_q[io_addr_q][io_bit_q]);
    endproperty
    a_io_clr: assert property (p_io_clr) else $error("io bit not cleared"); // RL9

    property p_bld;
        @(posedge clk_sys) disable iff (rst || !ce)
        (exec && is_from_t) |=> (gpr_q[$past(rd)][$past(idx)] == $past(status_flags_register_q[FL_T])
            && status_flags_register_q == $past(status_flags_register_q));
    endproperty
    a_bld: assert property (p_bld) else $error("bit load wrong"); // RL15

    property p_shl;
        @(posedge clk_sys) disable iff (rst || !ce)
        (exec && op == OP_SHL) |=> (gpr_q[$past(rd)] == {$past(rd_val[6:0]), 1'b0}
            && status_flags_register_q[FL_C] == $past(rd_val[7]));
    endproperty
    a_shl: assert property (p_shl) else $error("left shift wrong"); // RL10

    property p_bst;
        @(posedge clk_sys) disable iff (rst || !ce)
        (exec && is_to_t) |=> (status_flags_register_q[FL_T] == $past(bit_sel));
    endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong"); // RL14

    property p_swap;
        @(posedge clk_sys) disable iff (rst || !ce)
        (exec && is_swap) |=> (gpr_q[$past(rd)] == {$past(rd_val[3:0]), $past(rd_val[7:4])}
            && status_flags_register_q == $past(status_flags_register_q));
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong"); // RL18

    property p_flag_idx;
        @(posedge clk_sys) disable iff (rst || !ce)
        (exec && is_fl_zero) |=> (!status_flags_register_q[$past(idx)]);
    endproperty
    a_flag_idx: assert property (p_flag_idx) else $error("flag clear wrong"); // RL19

endmodule : fbbse_core

//--- testbench/tb.sv
// Self-checking bench for the flag, branch, bit and shift execution block.
// Assumes the core is driven only through its APB port and ce; busy, pready, pc_out and the flag output are also sampled directly.
`timescale 1ns/1ps
module tb;
    import fbbse_pkg::*;

    // Clock, reset and bus signals
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] pc_out;
    logic [7:0] status_flags_register_out;
    logic busy;

    // Reference model state
    int fails = 0;
    int n_checks = 0;
    logic [15:0] lfsr_q = 16'h0030;
    logic [15:0] pc_m;
    logic [7:0] sr_m;
    logic [1:0] cyc_m;
    logic bad_m;
    logic [7:0] gpr_m [32];
    logic [7:0] io_m [64];

    fbbse_core fbbse_core_i (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pc_out(pc_out), .status_flags_register_out(status_flags_register_out),
        .busy(busy)
    );

    // Free-running 100 MHz clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // Pseudo-random byte source
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function logic [7:0] rnd8();
        lfsr_q = lfsr_next(lfsr_q);
        return lfsr_q[7:0];
    endfunction : rnd8

    // Single comparison point
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    // One APB transfer: setup, then access until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            $display("MISMATCH t=%0t bus wait too long", $time);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, 32'h0);
    endtask : rd_chk

    task automatic set_sr(input logic [7:0] v);
        wr(ADDR_STATUS_FLAGS_REGISTER, {24'h0, v});
        sr_m = v;
    endtask : set_sr

    // Issue one instruction and advance the model
    task automatic exec(input logic [4:0] op, input logic [2:0] idx, input logic [7:0] opd);
        logic [7:0] v;
        logic [7:0] r;
        logic c;
        logic t;
        wr(ADDR_INSTR, {16'h0, op, idx, opd});
        v = gpr_m[opd[4:0]];
        c = sr_m[FL_C];
        t = 1'b0;
        cyc_m = CYC_ONE;
        case (op)
            OP_BR_HC_LOW: t = ~sr_m[FL_H];
            OP_BR_T_HIGH: t = sr_m[FL_T];
            OP_BR_T_LOW: t = ~sr_m[FL_T];
            OP_BR_V_HIGH: t = sr_m[FL_V];
            OP_BR_V_LOW: t = ~sr_m[FL_V];
            OP_BR_IRQ_ON: t = sr_m[FL_I];
            OP_BR_IRQ_OFF: t = ~sr_m[FL_I];
            OP_IO_SET: io_m[opd[5:0]][idx] = 1'b1;
            OP_IO_CLR: io_m[opd[5:0]][idx] = 1'b0;
            OP_SHL: {c, r} = {v, 1'b0};
            OP_SHR: {r, c} = {1'b0, v};
            OP_ROL: {c, r} = {v, c};
            OP_ROR: {r, c} = {c, v};
            OP_SWAP: gpr_m[opd[4:0]] = {v[3:0], v[7:4]};
            OP_BIT_TO_T: sr_m[FL_T] = v[idx];
            OP_T_TO_BIT: gpr_m[opd[4:0]][idx] = sr_m[FL_T];
            OP_FLAG_ONE: sr_m[idx] = 1'b1;
            OP_FLAG_ZERO: sr_m[idx] = 1'b0;
            default: bad_m = 1'b1;
        endcase
        if (op >= OP_SHL && op <= OP_ROR) begin
            gpr_m[opd[4:0]] = r;
            sr_m[FL_C] = c;
            sr_m[FL_Z] = (r == 8'h00);
            sr_m[FL_N] = r[7];
            sr_m[FL_V] = r[7] ^ c;
        end
        if (op == OP_IO_SET || op == OP_IO_CLR || t)
            cyc_m = CYC_TWO;
        if (t)
            pc_m = pc_m + {{8{opd[7]}}, opd};
        pc_m = pc_m + 16'h1;
    endtask : exec

    // Compare pc, flags, status and the addressed register and I/O byte with the model
    task automatic verify(input logic [7:0] opd);
        rd_chk(ADDR_PC, {16'h0, pc_m});
        rd_chk(ADDR_STATUS_FLAGS_REGISTER, {24'h0, sr_m});
        rd_chk(ADDR_STATUS, {28'h0, cyc_m, bad_m, 1'b0});
        rd_chk({PAGE_GPR, 1'b0, opd[4:0], 2'b00}, {24'h0, gpr_m[opd[4:0]]});
        rd_chk({PAGE_IO, opd[5:0], 2'b00}, {24'h0, io_m[opd[5:0]]});
    endtask : verify

    // Watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        final_report();
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        logic e;
        logic [7:0] o;
        pc_m = PC_RST;
        sr_m = STATUS_FLAGS_REGISTER_RST;
        bad_m = 1'b0;
        cyc_m = CYC_ONE;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(ADDR_PC, 32'h0);
        rd_chk(ADDR_STATUS_FLAGS_REGISTER, 32'h0);
        rd_chk(ADDR_STATUS, {28'h0, CYC_ONE, 2'b00});
        // Preload register and I/O arrays, which have no reset
        for (int i = 0; i < 32; i++) begin
            gpr_m[i] = rnd8();
            wr({PAGE_GPR, 1'b0, i[4:0], 2'b00}, {24'h0, gpr_m[i]});
        end
        for (int i = 0; i < 64; i++) begin
            io_m[i] = rnd8();
            wr({PAGE_IO, i[5:0], 2'b00}, {24'h0, io_m[i]});
        end
        // Every branch kind, random flags and signed offsets
        for (int k = 0; k < 42; k++) begin
            set_sr(rnd8());
            exec(5'(k % 7), 3'h0, rnd8());
            verify(8'h00);
        end
        // Second cycle of a taken branch holds the bus off
        set_sr(8'h80);
        exec(OP_BR_IRQ_ON, 3'h0, 8'hfe);
        @(negedge clk_sys);
        chk({31'h0, busy}, 32'h1);
        chk({31'h0, pready}, 32'h0);
        verify(8'h00);
        // Shifts, rotates and swap
        for (int k = 0; k < 25; k++) begin
            set_sr(rnd8());
            o = rnd8();
            exec(5'(OP_SHL + k % 5), 3'h0, o);
            verify(o);
        end
        // Bit moves to and from the transfer flag
        for (int k = 0; k < 12; k++) begin
            set_sr(rnd8());
            o = rnd8();
            exec(5'(OP_BIT_TO_T + k % 2), 3'(k % 8), o);
            verify(o);
        end
        // Indexed flag set and clear on every flag, back to back
        for (int k = 0; k < 16; k++) begin
            exec(5'(OP_FLAG_ONE + k / 8), 3'(k % 8), 8'h00);
            @(negedge clk_sys);
            chk({24'h0, status_flags_register_out}, {24'h0, sr_m});
        end
        verify(8'h00);
        // I/O bit set and clear, flags held
        for (int k = 0; k < 10; k++) begin
            set_sr(rnd8());
            o = rnd8();
            exec(5'(OP_IO_SET + k % 2), 3'(o % 8), o);
            verify(o);
        end
        // Undefined opcode flags an error, write one clears it
        exec(5'h07, 3'h0, 8'h00);
        rd_chk(ADDR_INSTR, 32'h0000_3800);
        verify(8'h00);
        wr(ADDR_STATUS, 32'h2);
        bad_m = 1'b0;
        // Program counter is writable from the bus
        wr(ADDR_PC, 32'h0000_1234);
        pc_m = 16'h1234;
        verify(8'h00);
        // Unmapped address is refused
        apb(1'b0, 12'h300, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        // Clock enable low freezes a taken branch in its second cycle
        set_sr(8'h80);
        exec(OP_BR_IRQ_ON, 3'h0, 8'h10);
        ce <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, busy}, 32'h1);
        chk({31'h0, pready}, 32'h0);
        chk({16'h0, pc_out}, {16'h0, pc_m - 16'h0011});
        @(posedge clk_sys);
        ce <= 1'b1;
        verify(8'h00);
        final_report();
    end
endmodule : tb
